// ==== pkg/dlms_map.svh ====
// Offsets, field positions, reset values and timing counts of the DLL mode switch sequence.
`ifndef DLMS_MAP_SVH
`define DLMS_MAP_SVH
`define DLMS_CLK_PERIOD_PS 8000
`define DLMS_NS_TO_CYC(ns) (((ns) * 1000 + `DLMS_CLK_PERIOD_PS - 1) / `DLMS_CLK_PERIOD_PS)
`define DLMS_REG_CTRL 4'h0
`define DLMS_REG_STATUS 4'h4
`define DLMS_REG_MODE 4'h8
`define DLMS_REG_TIME0 4'hC
`define DLMS_CTRL_START_BIT 0
`define DLMS_CTRL_DIR_BIT 1
`define DLMS_CTRL_ZQ_BIT 2
`define DLMS_CTRL_ODTEN_BIT 3
`define DLMS_ADDR_DLL_OFF_BIT 0
`define DLMS_ADDR_DLL_RESET_BIT 8
`define DLMS_TMRD_CYC 8'h04
`define DLMS_TMOD_CYC 8'h0C
`define DLMS_TCKSRE_CYC 8'h05
`define DLMS_TCKSRX_CYC 8'h05
`define DLMS_TXS_NS 170
`define DLMS_TXS_CYC `DLMS_NS_TO_CYC(`DLMS_TXS_NS)
`define DLMS_TDLLK_CYC 512
`define DLMS_TZQOPER_CYC 512
`define DLMS_MODE_RESET 16'h0000
`endif

// ==== pkg/dlms_pkg.sv ====
// Types of the DLL mode switch sequence.
package dlms_pkg;
   typedef enum logic [2:0]
   {
      DLMS_CMD_NOP = 3'h0,
      DLMS_CMD_MRS = 3'h1,
      DLMS_CMD_SRE = 3'h2,
      DLMS_CMD_SRX = 3'h3,
      DLMS_CMD_ZQCL = 3'h4
   } dlms_cmd_t;
   typedef enum logic [1:0]
   {
      DLMS_MR_PRIMARY = 2'h0,
      DLMS_MR_EXT_ONE = 2'h1
   } dlms_mr_t;
endpackage : dlms_pkg

// ==== pkg/dlms_if.sv ====
// Command link between the controller and the DRAM model end.
`timescale 1ns/1ps
interface dlms_if;
   logic cke;
   logic odt;
   logic clk_run;
   dlms_pkg::dlms_cmd_t cmd;
   dlms_pkg::dlms_mr_t mr_sel;
   logic [15:0] addr;
   modport ctrl (output cke, output odt, output clk_run, output cmd, output mr_sel, output addr);
   modport dram (input cke, input odt, input clk_run, input cmd, input mr_sel, input addr);
endinterface : dlms_if

// ==== rtl/dlms_wait_counter.sv ====
// Down counter that times one wait interval.
`timescale 1ns/1ps
module dlms_wait_counter #(
   parameter int WIDTH = 10
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Load and status
   input wire logic load_i,
   input wire logic [WIDTH-1:0] value_i,
   output logic busy_o
);
   logic [WIDTH-1:0] count;
   if (WIDTH < 2)
      $error("dlms_wait_counter: WIDTH too small");
   assign busy_o = (count != '0);
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
         count <= '0;
      else if (load_i)
         count <= value_i;
      else if (busy_o)
         count <= count - 1'b1;
   end
endmodule : dlms_wait_counter

// ==== rtl/dlms_dram_end.sv ====
// DRAM end: tracks self refresh, DLL enable, DLL reset and command acceptance.
`timescale 1ns/1ps
`include "dlms_map.svh"
module dlms_dram_end (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Link
   dlms_if.dram link,
   // User side status
   output logic dll_enabled_o,
   output logic dll_reset_o,
   output logic self_refresh_o,
   output logic clock_ignored_o,
   output logic ready_o,
   output logic early_cmd_o
);
   logic [9:0] mod_count;
   logic [7:0] sre_count;
   logic [7:0] mrd_count;
   logic is_mrs;
   logic takes_cmd;
   logic too_early;
   assign is_mrs = (link.cmd == dlms_pkg::DLMS_CMD_MRS);
   assign takes_cmd = link.cmd != dlms_pkg::DLMS_CMD_NOP;
   assign ready_o = (mod_count == 10'h000);
   // A mode write only needs tMRD after the last one; any other command needs tMOD.
   assign too_early = is_mrs ? (mrd_count != 8'h00) : (takes_cmd && !ready_o);
   assign clock_ignored_o = self_refresh_o && (sre_count == 8'h00);
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         dll_enabled_o <= 1'b1;
         dll_reset_o <= 1'b0;
         self_refresh_o <= 1'b0;
         sre_count <= 8'h00;
         mod_count <= 10'h000;
         mrd_count <= 8'h00;
         early_cmd_o <= 1'b0;
      end
      else
      begin
         early_cmd_o <= too_early;
         dll_reset_o <= 1'b0;
         if (mod_count != 10'h000)
            mod_count <= mod_count - 10'h001;
         if (sre_count != 8'h00)
            sre_count <= sre_count - 8'h01;
         if (mrd_count != 8'h00)
            mrd_count <= mrd_count - 8'h01;
         if (link.cmd == dlms_pkg::DLMS_CMD_SRE)
         begin
            self_refresh_o <= 1'b1;
            sre_count <= `DLMS_TCKSRE_CYC;
         end
         if (link.cmd == dlms_pkg::DLMS_CMD_SRX)
            self_refresh_o <= 1'b0;
         if (is_mrs && link.mr_sel == dlms_pkg::DLMS_MR_EXT_ONE)
            dll_enabled_o <= !link.addr[`DLMS_ADDR_DLL_OFF_BIT];
         if (is_mrs && link.mr_sel == dlms_pkg::DLMS_MR_PRIMARY)
            dll_reset_o <= link.addr[`DLMS_ADDR_DLL_RESET_BIT];
         if (is_mrs)
         begin
            mod_count <= 10'(`DLMS_TMOD_CYC - 1);
            mrd_count <= 8'(`DLMS_TMRD_CYC - 1);
         end
      end
   end
endmodule : dlms_dram_end

// ==== rtl/dlms_ctrl_end.sv ====
// Controller end: sequences DLL off and DLL on switches across a self refresh clock change.
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "dlms_map.svh"
module dlms_ctrl_end #(
   parameter int DLLK_CYC = `DLMS_TDLLK_CYC,
   parameter int ZQOPER_CYC = `DLMS_TZQOPER_CYC
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Avalon-MM slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Link
   dlms_if.ctrl link
);
   typedef enum logic [10:0]
   {
      S_IDLE = 11'h001,
      S_MR_OFF = 11'h002,
      S_SRE = 11'h004,
      S_CLKCHG = 11'h008,
      S_SRX = 11'h010,
      S_MR_ON = 11'h020,
      S_MR_RST = 11'h040,
      S_MR_NEW = 11'h080,
      S_ZQ = 11'h100,
      S_RELOCK = 11'h200,
      S_DONE = 11'h400
   } dlms_state_t;
   if (DLLK_CYC < 1 || DLLK_CYC > 1023 || ZQOPER_CYC < 1 || ZQOPER_CYC > 1023)
      $error("dlms_ctrl_end: DLLK_CYC and ZQOPER_CYC must be 1..1023");
   dlms_state_t state;
   dlms_state_t next_state;
   logic go_dir_on;
   logic zq_en;
   logic odt_feat;
   logic busy;
   logic [15:0] new_mode;
   logic [9:0] next_wait;
   logic load;
   logic wait_busy;
   logic [9:0] lock_count;
   logic zq_issued;
   logic sel_ctrl;
   logic sel_status;
   logic sel_mode;
   logic start_req;
   logic step_ok;
   logic rd_done;
   dlms_pkg::dlms_cmd_t next_cmd;
   dlms_pkg::dlms_mr_t next_mr;
   logic [15:0] next_addr;
   // ******************************************************
   // Register access
   // ******************************************************
   // Reads take one wait state so that the registered read data stands when waitrequest drops.
   assign avs_waitrequest_o = avs_read_i && !rd_done;
   assign sel_ctrl = (avs_address_i == `DLMS_REG_CTRL);
   assign sel_status = (avs_address_i == `DLMS_REG_STATUS);
   assign sel_mode = (avs_address_i == `DLMS_REG_MODE);
   assign start_req = avs_write_i && sel_ctrl && avs_writedata_i[`DLMS_CTRL_START_BIT] && !busy;
   assign busy = (state != S_IDLE) && (state != S_DONE);
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         go_dir_on <= 1'b0;
         zq_en <= 1'b0;
         odt_feat <= 1'b0;
         new_mode <= `DLMS_MODE_RESET;
         avs_readdata_o <= 32'h0000_0000;
         rd_done <= 1'b0;
      end
      else
      begin
         if (avs_write_i && sel_ctrl && !busy)
         begin
            go_dir_on <= avs_writedata_i[`DLMS_CTRL_DIR_BIT];
            zq_en <= avs_writedata_i[`DLMS_CTRL_ZQ_BIT];
            odt_feat <= avs_writedata_i[`DLMS_CTRL_ODTEN_BIT];
         end
         if (avs_write_i && sel_mode && !busy)
            new_mode <= avs_writedata_i[15:0];
         rd_done <= avs_read_i && !rd_done;
         if (avs_read_i && !rd_done)
            avs_readdata_o <= sel_ctrl ? {28'h0000000, odt_feat, zq_en, go_dir_on, 1'b0} :
                              sel_status ? {19'h00000, state, zq_issued, busy} :
                              sel_mode ? {16'h0000, new_mode} : 32'h0000_0000;
      end
   end
   // ******************************************************
   // Sequencer
   // ******************************************************
   dlms_wait_counter #(
      .WIDTH(10)
   ) i_dlms_wait_counter (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .load_i(load),
      .value_i(next_wait),
      .busy_o(wait_busy)
   );
   assign step_ok = !wait_busy;
   always_comb
   begin
      next_state = state;
      next_cmd = dlms_pkg::DLMS_CMD_NOP;
      next_mr = dlms_pkg::DLMS_MR_PRIMARY;
      next_addr = 16'h0000;
      next_wait = 10'h000;
      load = 1'b0;
      unique case (state)
         S_IDLE, S_DONE:
         begin
            if (start_req)
               next_state = avs_writedata_i[`DLMS_CTRL_DIR_BIT] ? S_SRE : S_MR_OFF;
         end
         S_MR_OFF:
         begin
            next_cmd = dlms_pkg::DLMS_CMD_MRS;
            next_mr = dlms_pkg::DLMS_MR_EXT_ONE;
            next_addr = 16'h0001 << `DLMS_ADDR_DLL_OFF_BIT;
            next_wait = 10'(`DLMS_TMOD_CYC - 1);
            load = 1'b1;
            next_state = S_SRE;
         end
         S_SRE:
         begin
            if (step_ok)
            begin
               next_cmd = dlms_pkg::DLMS_CMD_SRE;
               next_wait = 10'(`DLMS_TCKSRE_CYC);
               load = 1'b1;
               next_state = S_CLKCHG;
            end
         end
         S_CLKCHG:
         begin
            if (step_ok)
            begin
               next_wait = 10'(`DLMS_TCKSRX_CYC);
               load = 1'b1;
               next_state = S_SRX;
            end
         end
         S_SRX:
         begin
            if (step_ok)
            begin
               next_cmd = dlms_pkg::DLMS_CMD_SRX;
               next_wait = 10'(`DLMS_TXS_CYC - 1);
               load = 1'b1;
               next_state = go_dir_on ? S_MR_ON : S_MR_NEW;
            end
         end
         S_MR_ON:
         begin
            if (step_ok)
            begin
               next_cmd = dlms_pkg::DLMS_CMD_MRS;
               next_mr = dlms_pkg::DLMS_MR_EXT_ONE;
               next_wait = 10'(`DLMS_TMRD_CYC - 1);
               load = 1'b1;
               next_state = S_MR_RST;
            end
         end
         S_MR_RST:
         begin
            if (step_ok)
            begin
               next_cmd = dlms_pkg::DLMS_CMD_MRS;
               next_mr = dlms_pkg::DLMS_MR_PRIMARY;
               next_addr = 16'h0001 << `DLMS_ADDR_DLL_RESET_BIT;
               next_wait = 10'(`DLMS_TMRD_CYC - 1);
               load = 1'b1;
               next_state = S_MR_NEW;
            end
         end
         S_MR_NEW:
         begin
            if (step_ok)
            begin
               next_cmd = dlms_pkg::DLMS_CMD_MRS;
               next_mr = dlms_pkg::DLMS_MR_PRIMARY;
               next_addr = go_dir_on ? (new_mode & ~(16'h0001 << `DLMS_ADDR_DLL_RESET_BIT)) : new_mode;
               next_wait = 10'(`DLMS_TMOD_CYC - 1);
               load = 1'b1;
               next_state = zq_en ? S_ZQ : S_RELOCK;
            end
         end
         S_ZQ:
         begin
            if (step_ok)
            begin
               next_cmd = dlms_pkg::DLMS_CMD_ZQCL;
               next_wait = 10'(ZQOPER_CYC - 1);
               load = 1'b1;
               next_state = S_RELOCK;
            end
         end
         S_RELOCK:
         begin
            if (step_ok && lock_count == 10'h000)
               next_state = S_DONE;
         end
         default:
            next_state = S_IDLE;
      endcase
   end
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state <= S_IDLE;
         link.cmd <= dlms_pkg::DLMS_CMD_NOP;
         link.mr_sel <= dlms_pkg::DLMS_MR_PRIMARY;
         link.addr <= 16'h0000;
         link.cke <= 1'b1;
         link.odt <= 1'b0;
         link.clk_run <= 1'b1;
         lock_count <= 10'h000;
         zq_issued <= 1'b0;
      end
      else
      begin
         state <= next_state;
         link.cmd <= next_cmd;
         link.mr_sel <= next_mr;
         link.addr <= next_addr;
         // CKE stays high except from self refresh entry until exit.
         if (next_cmd == dlms_pkg::DLMS_CMD_SRE)
            link.cke <= 1'b0;
         else if (next_cmd == dlms_pkg::DLMS_CMD_SRX)
            link.cke <= 1'b1;
         link.odt <= 1'b0;
         link.clk_run <= !(state == S_CLKCHG && step_ok);
         if (state == S_MR_RST && step_ok)
            lock_count <= 10'(DLLK_CYC);
         else if (lock_count != 10'h000)
            lock_count <= lock_count - 10'h001;
         if (start_req)
            zq_issued <= 1'b0;
         else if (next_cmd == dlms_pkg::DLMS_CMD_ZQCL)
            zq_issued <= 1'b1;
      end
   end
endmodule : dlms_ctrl_end

// ==== tb/dlms_check_sva.sv ====
// Link checker of the DLL mode switch sequence.
`timescale 1ns/1ps
module dlms_check_sva (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Link
   input wire logic cke,
   input wire logic odt,
   input wire logic clk_run,
   input wire dlms_pkg::dlms_cmd_t cmd,
   input wire dlms_pkg::dlms_mr_t mr_sel,
   input wire logic [15:0] addr
);
   wire nop = cmd == dlms_pkg::DLMS_CMD_NOP;
   wire mrs = cmd == dlms_pkg::DLMS_CMD_MRS;
   wire mrs_ext = mrs && mr_sel == dlms_pkg::DLMS_MR_EXT_ONE;
   wire mrs_pri = mrs && mr_sel == dlms_pkg::DLMS_MR_PRIMARY;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);
   sequence s_nop7;
      nop [*7];
   endsequence
   sequence s_tmrd;
      nop [*3];
   endsequence
   property p_odt_low;
      odt == 1'b0;
   endproperty
   property p_off_gap;
      mrs_ext && addr[0] |=> nop [*8] ##1 nop [*3] ##1 cmd == dlms_pkg::DLMS_CMD_SRE;
   endproperty
   property p_clk_hold;
      cmd == dlms_pkg::DLMS_CMD_SRE |=> clk_run [*5];
   endproperty
   property p_clk_stop;
      $fell(clk_run) |-> !cke;
   endproperty
   property p_clk_stable;
      cmd == dlms_pkg::DLMS_CMD_SRX |-> clk_run && $past(clk_run, 5);
   endproperty
   property p_cke_high;
      $fell(cke) |-> cmd == dlms_pkg::DLMS_CMD_SRE || $past(cmd) == dlms_pkg::DLMS_CMD_SRE;
   endproperty
   property p_txs;
      cmd == dlms_pkg::DLMS_CMD_SRX |=> s_nop7 ##1 s_nop7 ##1 s_nop7 ##1 mrs;
   endproperty
   property p_enable_reset;
      mrs_ext && !addr[0] |=> s_tmrd ##1 (mrs_pri && addr[8]);
   endproperty
   property p_update;
      mrs_pri && addr[8] |=> s_tmrd ##1 (mrs_pri && !addr[8]);
   endproperty
   property p_zq;
      cmd == dlms_pkg::DLMS_CMD_ZQCL |-> $past(cmd, 12) == dlms_pkg::DLMS_CMD_MRS;
   endproperty
   a_odt_low: assert property (p_odt_low) else $error("odt driven high");
   a_off_gap: assert property (p_off_gap) else $error("self refresh entry not tMOD after DLL off");
   a_clk_hold: assert property (p_clk_hold) else $error("clock changed before tCKSRE");
   a_clk_stop: assert property (p_clk_stop) else $error("clock changed outside self refresh");
   a_clk_stable: assert property (p_clk_stable) else $error("exit without stable clock");
   a_cke_high: assert property (p_cke_high) else $error("cke dropped outside entry");
   a_txs: assert property (p_txs) else $error("mode write not tXS after exit");
   a_enable_reset: assert property (p_enable_reset) else $error("DLL reset not tMRD after enable");
   a_update: assert property (p_update) else $error("mode update not tMRD after reset");
   a_zq: assert property (p_zq) else $error("long calibration before tMOD");
endmodule : dlms_check_sva

// ==== tb/dll_mode_switch_sequence_test.sv ====
// Self-checking bench of the DLL mode switch sequence.
`timescale 1ns/1ps
`include "dlms_map.svh"
module dll_mode_switch_sequence_test;
   localparam int DLLK = 20;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h00000000;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic dll_enabled_o;
   logic dll_reset_o;
   logic self_refresh_o;
   logic clock_ignored_o;
   logic ready_o;
   logic early_cmd_o;
   logic [31:0] rd;
   int gap;
   int n_errors = 0;
   int num_checks = 0;
   logic saw_early = 1'b0;
   dlms_if link ();
   dlms_ctrl_end #(.DLLK_CYC(DLLK), .ZQOPER_CYC(DLLK)) i_dlms_ctrl_end (.clock_i(clock_i), .resetn_i(resetn_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .link(link));
   dlms_dram_end i_dlms_dram_end (.clock_i(clock_i), .resetn_i(resetn_i), .link(link),
      .dll_enabled_o(dll_enabled_o), .dll_reset_o(dll_reset_o), .self_refresh_o(self_refresh_o),
      .clock_ignored_o(clock_ignored_o), .ready_o(ready_o), .early_cmd_o(early_cmd_o));
   dlms_check_sva i_dlms_check_sva (.clock_i(clock_i), .resetn_i(resetn_i), .cke(link.cke), .odt(link.odt),
      .clk_run(link.clk_run), .cmd(link.cmd), .mr_sel(link.mr_sel), .addr(link.addr));
   always #4 clock_i = ~clock_i;
   // The early command flag is a one-cycle pulse, so it is kept sticky for the closing check.
   always @(posedge clock_i)
      if (early_cmd_o === 1'b1)
         saw_early <= 1'b1;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : bus
   task automatic wait_cmd(input dlms_pkg::dlms_cmd_t c);
      gap = 0;
      do
      begin
         @(posedge clock_i);
         #1 gap++;
      end
      while (link.cmd !== c && gap < 4000);
      check(link.cmd, c);
   endtask : wait_cmd
   task automatic wait_idle;
      int n;
      n = 0;
      do
      begin
         bus(1'b0, `DLMS_REG_STATUS, 32'h00000000);
         n++;
      end
      while (rd[0] !== 1'b0 && n < 300);
   endtask : wait_idle
   task automatic t_reset;
      check({link.cke, link.odt, link.clk_run, link.cmd}, {3'h5, dlms_pkg::DLMS_CMD_NOP});
      resetn_i <= 1'b1;
      bus(1'b0, `DLMS_REG_MODE, 32'h00000000);
      check(rd, 32'h00000000);
      bus(1'b0, 4'h1, 32'h00000000);
      check(rd, 32'h00000000);
      check(dll_enabled_o, 1'b1);
      $display("test reset done");
   endtask : t_reset
   task automatic t_dll_off;
      bus(1'b1, `DLMS_REG_MODE, 32'h00001234);
      bus(1'b1, `DLMS_REG_CTRL, 32'h00000009);
      wait_cmd(dlms_pkg::DLMS_CMD_MRS);
      check({link.mr_sel, link.addr}, {dlms_pkg::DLMS_MR_EXT_ONE, 16'h0001});
      wait_cmd(dlms_pkg::DLMS_CMD_SRE);
      check(gap, `DLMS_TMOD_CYC);
      gap = 0;
      while (link.clk_run !== 1'b0 && gap < 4000)
      begin
         @(posedge clock_i);
         #1 gap++;
      end
      check(gap, `DLMS_TCKSRE_CYC + 1);
      @(posedge clock_i);
      #1 check({clock_ignored_o, self_refresh_o, link.cke, dll_enabled_o}, 4'hC);
      bus(1'b1, `DLMS_REG_MODE, 32'h00000055);
      wait_cmd(dlms_pkg::DLMS_CMD_SRX);
      wait_cmd(dlms_pkg::DLMS_CMD_MRS);
      check(gap, `DLMS_TXS_CYC);
      check({link.mr_sel, link.addr, link.cke}, {dlms_pkg::DLMS_MR_PRIMARY, 16'h1234, 1'b1});
      wait_idle;
      check(rd[0], 1'b0);
      bus(1'b0, `DLMS_REG_CTRL, 32'h00000000);
      check(rd, 32'h00000008);
      $display("test dll_off done");
   endtask : t_dll_off
   task automatic t_dll_on;
      bus(1'b1, `DLMS_REG_MODE, 32'h00001334);
      bus(1'b1, `DLMS_REG_CTRL, 32'h00000007);
      wait_cmd(dlms_pkg::DLMS_CMD_SRX);
      wait_cmd(dlms_pkg::DLMS_CMD_MRS);
      check(gap, `DLMS_TXS_CYC);
      check({link.mr_sel, link.addr}, {dlms_pkg::DLMS_MR_EXT_ONE, 16'h0000});
      wait_cmd(dlms_pkg::DLMS_CMD_MRS);
      check({gap[7:0], dll_enabled_o}, {`DLMS_TMRD_CYC, 1'b1});
      check({link.mr_sel, link.addr}, {dlms_pkg::DLMS_MR_PRIMARY, 16'h0100});
      @(posedge clock_i);
      #1 check(dll_reset_o, 1'b1);
      wait_cmd(dlms_pkg::DLMS_CMD_MRS);
      check(gap, `DLMS_TMRD_CYC - 1);
      check({link.mr_sel, link.addr}, {dlms_pkg::DLMS_MR_PRIMARY, 16'h1234});
      wait_cmd(dlms_pkg::DLMS_CMD_ZQCL);
      check({gap[7:0], ready_o}, {`DLMS_TMOD_CYC, 1'b1});
      repeat (DLLK - 6) @(posedge clock_i);
      bus(1'b0, `DLMS_REG_STATUS, 32'h00000000);
      check(rd[0], 1'b1);
      wait_idle;
      check({rd[1:0], saw_early}, 3'h4);
      $display("test dll_on done");
   endtask : t_dll_on
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   initial
   begin
      #100000;
      n_errors++;
      final_report;
   end
   initial
   begin
      repeat (10) @(posedge clock_i);
      t_reset;
      t_dll_off;
      t_dll_on;
      final_report;
   end
endmodule : dll_mode_switch_sequence_test
